// *** src/pll_clk_defines.svh ***
// pll_clk_defines.svh: offsets, field positions, reset values and fixed ratios
// of the pll clock configuration block; assumes a byte-addressed 32-bit bus.
`ifndef PLL_CLK_DEFINES_SVH
`define PLL_CLK_DEFINES_SVH

// ----------------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------------
`define OFS_SYNTH      5'h00
`define OFS_REF_DIVIDE_FIELD     5'h04
`define OFS_POST_DIVIDE_FIELD    5'h08
`define OFS_FLAGS      5'h0C
`define OFS_CTRL       5'h10
`define OFS_IRQEN      5'h14
`define OFS_RATIO      5'h18

// ----------------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------------
`define BIT_TIMEOUT    7
`define BIT_POWERON_RESET_FLAG       6
`define BIT_LOWVOLT_RESET_FLAG       5
`define BIT_LOCKCHG    4
`define BIT_LOCK       3
`define BIT_BADADDR    2
`define BIT_OSCCHG     1
`define BIT_OSCQ       0
`define BIT_PLL_SOURCE_SELECT     7
`define BIT_EXTOSC     1
`define BIT_PROTECT    0

// ----------------------------------------------------------------------------
// reset values and fixed ratios
// ----------------------------------------------------------------------------
`define RST_SYNTH      8'h01
`define RST_REF_DIVIDE_FIELD     8'h00
`define RST_POST_DIVIDE_FIELD    5'h03
`define UNLOCK_RATIO   6'h04
`define BUS_RATIO      2'h2
`define FIXED_REF_RNG  2'h0

`endif

// *** src/pll_clk_pkg.sv ***
// pll_clk_pkg: types shared by the pll clock configuration block.
// assumes pll_clk_defines.svh supplies the numeric constants.
package pll_clk_pkg;

  // settings handed to the analog pll and the clock tree
  typedef struct packed {
    logic [1:0] vco_range_field;
    logic [5:0] multiplier_field;
    logic [1:0] ref_range_field;
    logic [3:0] ref_divide_field;
    logic [4:0] post_divide_field;
    logic       ext_osc_enable;
  } pll_cfg_t;

  // frequency ratios that follow from the settings and the lock state
  typedef struct packed {
    logic [7:0] vco_mult;
    logic [5:0] pll_div;
    logic [7:0] bus_div;
  } pll_ratio_t;

endpackage : pll_clk_pkg

// *** src/pll_clock_config_and_flags.sv ***
// pll_clock_config_and_flags: pll settings, post divider and status flags,
// reached over an avalon-mm slave with waitrequest.
// assumes lock_i and osc_good_i come from the analog side on other clocks,
// all other inputs are synchronous to mclk_i.
`timescale 1ns/1ps
`include "pll_clk_defines.svh"

// Notes on behaviour
// RULE1: pll writes need protect clear, pll select set
// RULE2: accepted pll write clears lock and osc status
// RULE3: vco equals twice reference times multiplier plus one
// RULE4: software picks vco range code per frequency
// RULE5: reference is oscillator divided, else internal 1mhz
// RULE6: software picks reference range code per frequency
// RULE7: internal reference fixes filter at lowest range
// RULE8: post divider writable only with pll select
// RULE9: pll output is vco over post or four
// RULE10: bus clock is half pll output
// RULE11: timeout flag bit7, write one clears, irq
// RULE12: power-on flag bit6, kept over system reset
// RULE13: low-voltage flag bit5, also set at power-on
// RULE14: bad-address flag bit2, cleared at power-on
// RULE15: lock change flag bit4, either direction, irq
// RULE16: lock status bit3 read only
// RULE17: osc change flag bit1, write one clears, irq
// RULE18: osc status cleared on full stop, gates can clock
// RULE19: losing lock clears osc status except pseudo stop
// RULE20: pll keeps running at all times
// RULE21: pll select forced while osc not qualified
// RULE22: flag set beats same-cycle clear
module pll_clock_config_and_flags
  import pll_clk_pkg::*;
(
  input  wire logic        mclk_i,
  input  wire logic        rst_i,
  input  wire logic        ce_i,
  input  wire logic        por_i,
  input  wire logic        lvr_i,
  input  wire logic        bad_addr_rst_i,
  input  wire logic        rti_timeout_i,
  input  wire logic        full_stop_i,
  input  wire logic        pseudo_stop_i,
  input  wire logic        lock_i,
  input  wire logic        osc_good_i,
  input  wire logic [4:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  output pll_cfg_t         pll_cfg_o,
  output logic      [1:0]  filter_range_o,
  output pll_ratio_t       ratio_o,
  output logic             pll_run_o,
  output logic             pll_restart_o,
  output logic             pll_source_select_o,
  output logic             can_osc_clk_en_o,
  output logic             irq_o
);

  // --------------------------------------------------------------------------
  // state
  // --------------------------------------------------------------------------
  logic [7:0]  synth_r;
  logic [7:0]  ref_divide_field_r;
  logic [4:0]  post_divide_field_r;
  logic        pll_sel_r;
  logic        ext_osc_r;
  logic        protect_r;
  logic        irqen_timeout_r;
  logic        irqen_lock_r;
  logic        irqen_osc_r;
  logic        timeout_flag_r;
  logic        poweron_flag_r;
  logic        lowvolt_flag_r;
  logic        lock_chg_flag_r;
  logic        bad_addr_flag_r;
  logic        osc_chg_flag_r;
  logic        lock_r;
  logic        osc_q_r;
  logic        relock_wait_r;
  logic        restart_r;
  logic        lock_meta_r;
  logic        lock_sync_r;
  logic        osc_meta_r;
  logic        osc_sync_r;
  logic        done_r;
  logic [31:0] rdata_r;
  pll_ratio_t  ratio_r;
  logic [1:0]  filter_r;

  // --------------------------------------------------------------------------
  // bus decode
  // --------------------------------------------------------------------------
  // map by byte offset: 00 synthesizer, 04 reference divider, 08 post
  // divider, 0C flags, 10 control (pll select, ext osc, protect), 14 irq
  // enables, 18 ratios (read only); other offsets read 0, writes vanish.
  // only byte lane 0 holds writable register bits, so a write without it is dropped
  // one wait state: the request is taken at the edge where done_r is high
  wire         req      = avs_read | avs_write;
  wire         take     = req & done_r;
  wire         wr_take  = avs_write & take & avs_byteenable[0];
  wire [7:0]   wd       = avs_writedata[7:0];
  wire         hit_syn  = avs_address == `OFS_SYNTH;
  wire         hit_ref  = avs_address == `OFS_REF_DIVIDE_FIELD;
  wire         hit_post = avs_address == `OFS_POST_DIVIDE_FIELD;
  wire         hit_flag = avs_address == `OFS_FLAGS;
  wire         hit_ctrl = avs_address == `OFS_CTRL;
  wire         hit_irq  = avs_address == `OFS_IRQEN;
  wire         hit_rat  = avs_address == `OFS_RATIO;

  // RULE1: protect and pll select gate
  wire         pll_wr_ok  = ~protect_r & pll_sel_r;
  wire         wr_syn     = wr_take & hit_syn & pll_wr_ok;
  wire         wr_ref     = wr_take & hit_ref & pll_wr_ok;
  // RULE8: post divider needs pll select
  wire         wr_post    = wr_take & hit_post & pll_sel_r;
  wire         wr_flag    = wr_take & hit_flag;
  wire         wr_ctrl    = wr_take & hit_ctrl & ~protect_r;
  wire         wr_write_protect    = wr_take & hit_ctrl;
  wire         wr_irq     = wr_take & hit_irq;
  // RULE2: accepted pll write drops lock
  wire         pll_change = wr_syn | wr_ref;

  // --------------------------------------------------------------------------
  // lock and oscillator status
  // --------------------------------------------------------------------------
  // after a retune the old lock report is not trusted until the pll has
  // reported unlock once; this hides a stale lock from the analog side
  wire         wait_nxt  = pll_change | (relock_wait_r & lock_sync_r);
  wire         lock_nxt  = lock_sync_r & ~wait_nxt;
  // RULE19: lock loss drops osc status
  wire         lock_ok   = lock_nxt | pseudo_stop_i;
  // RULE18: full stop drops osc status
  wire         osc_nxt   = osc_sync_r & lock_ok & ~full_stop_i & ~pll_change;
  wire         lock_evt  = lock_nxt ^ lock_r;
  wire         osc_evt   = osc_nxt ^ osc_q_r;

  // --------------------------------------------------------------------------
  // flag next values
  // --------------------------------------------------------------------------
  // RULE22: set terms sit outside the clear
  // RULE11: timeout flag
  wire clr_to   = wr_flag & wd[`BIT_TIMEOUT];
  wire to_nxt   = rti_timeout_i | (timeout_flag_r & ~clr_to);
  // RULE12: power-on flag
  wire clr_por  = wr_flag & wd[`BIT_POWERON_RESET_FLAG];
  wire por_nxt  = poweron_flag_r & ~clr_por;
  // RULE13: low-voltage flag
  wire clr_lvr  = wr_flag & wd[`BIT_LOWVOLT_RESET_FLAG];
  wire lvr_nxt  = lvr_i | (lowvolt_flag_r & ~clr_lvr);
  // RULE14: bad-address flag
  wire clr_bad  = wr_flag & wd[`BIT_BADADDR];
  wire bad_nxt  = bad_addr_rst_i | (bad_addr_flag_r & ~clr_bad);
  // lock_evt also fires on the forced drop after a retune
  // RULE15: lock change flag
  wire clr_lck  = wr_flag & wd[`BIT_LOCKCHG];
  wire lck_nxt  = lock_evt | (lock_chg_flag_r & ~clr_lck);
  // RULE17: osc change flag
  wire clr_osc  = wr_flag & wd[`BIT_OSCCHG];
  wire oscf_nxt = osc_evt | (osc_chg_flag_r & ~clr_osc);

  // --------------------------------------------------------------------------
  // pll select
  // --------------------------------------------------------------------------
  // RULE21: forced while osc unqualified
  wire sel_nxt  = ~osc_nxt | (wr_ctrl ? wd[`BIT_PLL_SOURCE_SELECT] : pll_sel_r);

  // --------------------------------------------------------------------------
  // read mux
  // --------------------------------------------------------------------------
  wire [7:0] flag_rd = {timeout_flag_r, poweron_flag_r, lowvolt_flag_r,
                        lock_chg_flag_r,
                        // RULE16: lock status read only
                        lock_r,
                        bad_addr_flag_r, osc_chg_flag_r, osc_q_r};
  wire [7:0] ctrl_rd = {pll_sel_r, 5'h00, ext_osc_r, protect_r};
  wire [7:0] irq_rd  = {irqen_timeout_r, 2'h0, irqen_lock_r,
                        2'h0, irqen_osc_r, 1'h0};
  wire [7:0] ref_rd  = {ref_divide_field_r[7:6], 2'h0, ref_divide_field_r[3:0]};
  wire [31:0] rd_mux =
      hit_syn  ? {24'h000000, synth_r} :
      hit_ref  ? {24'h000000, ref_rd} :
      hit_post ? {27'h0000000, post_divide_field_r} :
      hit_flag ? {24'h000000, flag_rd} :
      hit_ctrl ? {24'h000000, ctrl_rd} :
      hit_irq  ? {24'h000000, irq_rd} :
      hit_rat  ? {10'h000, ratio_o} :
                 32'h00000000;

  // --------------------------------------------------------------------------
  // frequency ratios
  // --------------------------------------------------------------------------
  // RULE3: vco factor 2 x (m + 1)
  wire [7:0] vco_mult = {1'b0, synth_r[5:0], 1'b0} + 8'h02;
  // RULE9: divide by four while unlocked
  wire [5:0] pll_div  = lock_r ? ({1'b0, post_divide_field_r} + 6'h01) : `UNLOCK_RATIO;
  // RULE10: bus runs at half the selected source
  wire [7:0] bus_div  = pll_sel_r ? {1'b0, pll_div, 1'b0} : {6'h00, `BUS_RATIO};
  wire pll_ratio_t ratio_nxt  = {vco_mult, pll_div, bus_div};
  // RULE7: internal reference pins the filter
  wire [1:0]       filter_nxt = ext_osc_r ? ref_divide_field_r[7:6] : `FIXED_REF_RNG;

  // --------------------------------------------------------------------------
  // registered ratio and filter outputs
  // --------------------------------------------------------------------------
  // these follow the registers one edge late; they update under reset too,
  // so a reset held two edges leaves them matching the reset settings and
  // the reset branch stays free of derived values
  always_ff @(posedge mclk_i) begin
    if (rst_i | por_i | ce_i) begin
      ratio_r  <= ratio_nxt;
      filter_r <= filter_nxt;
    end
  end

  // --------------------------------------------------------------------------
  // synchronisers for analog status
  // --------------------------------------------------------------------------
  // only the second stage is read; the first may settle late
  always_ff @(posedge mclk_i) begin
    if (rst_i | por_i) begin
      lock_meta_r <= 1'b0;
      lock_sync_r <= 1'b0;
      osc_meta_r  <= 1'b0;
      osc_sync_r  <= 1'b0;
    end else if (ce_i) begin
      lock_meta_r <= lock_i;
      lock_sync_r <= lock_meta_r;
      osc_meta_r  <= osc_good_i;
      osc_sync_r  <= osc_meta_r;
    end
  end

  // --------------------------------------------------------------------------
  // bus handshake
  // --------------------------------------------------------------------------
  // done_r freezes with ce_i, so a request made while ce_i is low stays
  // in its wait state until the enable returns
  always_ff @(posedge mclk_i) begin
    if (rst_i | por_i) begin
      done_r  <= 1'b0;
      rdata_r <= 32'h00000000;
    end else if (ce_i) begin
      done_r <= req & ~done_r;
      if (avs_read & ~done_r) begin
        rdata_r <= rd_mux;
      end
    end
  end

  // --------------------------------------------------------------------------
  // configuration registers
  // --------------------------------------------------------------------------
  always_ff @(posedge mclk_i) begin
    if (rst_i | por_i) begin
      synth_r   <= `RST_SYNTH;
      ref_divide_field_r  <= `RST_REF_DIVIDE_FIELD;
      post_divide_field_r <= `RST_POST_DIVIDE_FIELD;
    end else if (ce_i) begin
      if (wr_syn) begin
        synth_r <= wd;
      end
      if (wr_ref) begin
        ref_divide_field_r <= {wd[7:6], 2'h0, wd[3:0]};
      end
      if (wr_post) begin
        post_divide_field_r <= wd[4:0];
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i | por_i) begin
      pll_sel_r       <= 1'b1;
      ext_osc_r       <= 1'b0;
      protect_r       <= 1'b0;
      irqen_timeout_r <= 1'b0;
      irqen_lock_r    <= 1'b0;
      irqen_osc_r     <= 1'b0;
    end else if (ce_i) begin
      pll_sel_r <= sel_nxt;
      if (wr_ctrl) begin
        ext_osc_r <= wd[`BIT_EXTOSC];
      end
      if (wr_write_protect) begin
        protect_r <= wd[`BIT_PROTECT];
      end
      if (wr_irq) begin
        irqen_timeout_r <= wd[`BIT_TIMEOUT];
        irqen_lock_r    <= wd[`BIT_LOCKCHG];
        irqen_osc_r     <= wd[`BIT_OSCCHG];
      end
    end
  end

  // --------------------------------------------------------------------------
  // status and event flags
  // --------------------------------------------------------------------------
  always_ff @(posedge mclk_i) begin
    if (rst_i | por_i) begin
      timeout_flag_r  <= 1'b0;
      lock_chg_flag_r <= 1'b0;
      osc_chg_flag_r  <= 1'b0;
      lock_r          <= 1'b0;
      osc_q_r         <= 1'b0;
      relock_wait_r   <= 1'b0;
      restart_r       <= 1'b0;
    end else if (ce_i) begin
      timeout_flag_r  <= to_nxt;
      lock_chg_flag_r <= lck_nxt;
      osc_chg_flag_r  <= oscf_nxt;
      lock_r          <= lock_nxt;
      osc_q_r         <= osc_nxt;
      relock_wait_r   <= wait_nxt;
      restart_r       <= pll_change;
    end
  end

  // reset causes survive system reset; only power-on redefines them
  always_ff @(posedge mclk_i) begin
    if (por_i) begin
      // RULE12: set at power-on
      poweron_flag_r  <= 1'b1;
      // RULE13: set at power-on too
      lowvolt_flag_r  <= 1'b1;
      // RULE14: cleared at power-on
      bad_addr_flag_r <= 1'b0;
    end else if (ce_i) begin
      poweron_flag_r  <= por_nxt;
      lowvolt_flag_r  <= lvr_nxt;
      bad_addr_flag_r <= bad_nxt;
    end
  end

  // --------------------------------------------------------------------------
  // outputs
  // --------------------------------------------------------------------------
  assign avs_waitrequest = req & ~done_r;
  assign avs_readdata    = rdata_r;

  always_comb begin
    pll_cfg_o.vco_range_field   = synth_r[7:6];
    pll_cfg_o.multiplier_field  = synth_r[5:0];
    pll_cfg_o.ref_range_field   = ref_divide_field_r[7:6];
    // RULE5: divider only matters with ext osc
    pll_cfg_o.ref_divide_field  = ref_divide_field_r[3:0];
    pll_cfg_o.post_divide_field = post_divide_field_r;
    pll_cfg_o.ext_osc_enable    = ext_osc_r;
  end

  assign filter_range_o = filter_r;
  assign ratio_o        = ratio_r;

  // RULE20: the vco also feeds the oscillator filter, so it never stops
  assign pll_run_o = 1'b1;

  // one-cycle pulse telling the analog side that its synthesizer or reference divider settings moved
  assign pll_restart_o       = restart_r;
  assign pll_source_select_o = pll_sel_r;

  // RULE18: can oscillator clock gate
  assign can_osc_clk_en_o = osc_q_r;

  // RULE11: timeout request
  // RULE15: lock change request
  // RULE17: osc change request
  assign irq_o = (timeout_flag_r & irqen_timeout_r) |
                 (lock_chg_flag_r & irqen_lock_r) |
                 (osc_chg_flag_r & irqen_osc_r);

endmodule : pll_clock_config_and_flags

// *** test/pll_clk_props.sv ***
// checker of pll_clock_config_and_flags: handshake, clock gating, ratios.
// assumes one clock, mclk_i, and the resets rst_i and por_i, both high.
`timescale 1ns/1ps
module pll_clk_props
  import pll_clk_pkg::*;
(
  input wire logic        mclk_i,
  input wire logic        rst_i,
  input wire logic        por_i,
  input wire logic        full_stop_i,
  input wire logic [4:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  input wire pll_cfg_t    pll_cfg_o,
  input wire logic [1:0]  filter_range_o,
  input wire pll_ratio_t  ratio_o,
  input wire logic        pll_run_o,
  input wire logic        pll_restart_o,
  input wire logic        pll_source_select_o,
  input wire logic        can_osc_clk_en_o
);
  // -----
  // properties
  // -----
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i || por_i);
  wire req = avs_read || avs_write;
  sequence s_one_wait;
    avs_waitrequest ##1 !avs_waitrequest;
  endsequence
  sequence s_restart_pulse;
    !can_osc_clk_en_o && pll_source_select_o ##1 !pll_restart_o;
  endsequence
  a_one_wait: assert property ($rose(req) |-> s_one_wait)
    else $error("bus request not answered after one wait cycle");
  a_read_range: assert property (avs_read && !avs_waitrequest |-> avs_readdata[31:22] == 10'h000
    && (avs_address <= 5'h18 || avs_readdata == 32'h0)) else $error("read data outside map");
  a_pll_runs: assert property (pll_run_o) else $error("pll stopped");
  a_full_stop_gate: assert property (full_stop_i |=> !can_osc_clk_en_o) else $error("osc not gated");
  a_select_forced: assert property (!can_osc_clk_en_o |-> pll_source_select_o)
    else $error("pll select not forced");
  a_restart_clears: assert property (pll_restart_o |-> s_restart_pulse)
    else $error("restart did not clear status");
  a_unlock_div: assert property (pll_restart_o |=> ratio_o.pll_div == 6'h04)
    else $error("unlocked divide not four");
  a_filter_fixed: assert property ($stable(pll_cfg_o) |-> filter_range_o ==
    (pll_cfg_o.ext_osc_enable ? pll_cfg_o.ref_range_field : 2'h0)) else $error("filter range wrong");
  a_vco_ratio: assert property ($stable(pll_cfg_o) |->
    ratio_o.vco_mult == {({1'b0, pll_cfg_o.multiplier_field} + 7'h01), 1'b0}) else $error("vco ratio wrong");
  a_bus_ratio: assert property ($stable(ratio_o.pll_div) && $stable(pll_source_select_o) |->
    ratio_o.bus_div == (pll_source_select_o ? {1'b0, ratio_o.pll_div, 1'b0} : 8'h02)) else $error("bus ratio wrong");
endmodule : pll_clk_props

bind pll_clock_config_and_flags pll_clk_props i_props (.mclk_i, .rst_i, .por_i, .full_stop_i, .avs_address,
  .avs_read, .avs_write, .avs_readdata, .avs_waitrequest, .pll_cfg_o, .filter_range_o, .ratio_o, .pll_run_o,
  .pll_restart_o, .pll_source_select_o, .can_osc_clk_en_o);

// *** test/test_pll_clock_config_and_flags.sv ***
// bench of pll_clock_config_and_flags: avalon tasks, integer model, scenarios.
// assumes the package, defines and design are compiled first; 25 MHz clock.
`timescale 1ns/1ps
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin miscompares++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, (g), (e)); end end
module test_pll_clock_config_and_flags
  import pll_clk_pkg::*;
;
  logic        mclk_i, rst_i, por_i, ce_i, lvr_i, bad_addr_rst_i, rti_timeout_i;
  logic        full_stop_i, pseudo_stop_i, lock_i, osc_good_i, avs_read, avs_write, avs_waitrequest;
  logic [4:0]  avs_address;
  logic [31:0] avs_writedata, avs_readdata, q;
  logic [31:0] seed = 32'h7A90;
  logic [3:0]  avs_byteenable;
  pll_cfg_t    pll_cfg_o;
  pll_ratio_t  ratio_o;
  logic [1:0]  filter_range_o;
  logic        pll_run_o, pll_restart_o, pll_source_select_o, can_osc_clk_en_o, irq_o;
  int          miscompares = 0, samples_checked = 0;
  int          synth = 1, refd = 0, post = 3, flg = 8'h60, lk = 0, os = 0, sel = 1, ext = 0, write_protect = 0, ien = 0;

  pll_clock_config_and_flags i_dut (.mclk_i, .rst_i, .ce_i, .por_i, .lvr_i, .bad_addr_rst_i, .rti_timeout_i,
    .full_stop_i, .pseudo_stop_i, .lock_i, .osc_good_i, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable, .avs_readdata, .avs_waitrequest, .pll_cfg_o, .filter_range_o, .ratio_o, .pll_run_o,
    .pll_restart_o, .pll_source_select_o, .can_osc_clk_en_o, .irq_o);

  initial begin
    mclk_i = 1'b0;
    forever #20 mclk_i = ~mclk_i;
  end

  // -----
  // model and bus tasks
  // -----
  function logic [31:0] lfsr(input logic [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  function int exp_rd(input logic [4:0] a);
    int pd;
    pd = lk ? post + 1 : 4;
    case (a)
      5'h00: exp_rd = synth;
      5'h04: exp_rd = refd;
      5'h08: exp_rd = post;
      5'h0C: exp_rd = flg | lk << 3 | os;
      5'h10: exp_rd = sel << 7 | ext << 1 | write_protect;
      5'h14: exp_rd = ien;
      5'h18: exp_rd = (2 * (synth % 64) + 2) << 14 | pd << 8 | (sel ? 2 * pd : 2);
      default: exp_rd = 0;
    endcase
  endfunction : exp_rd

  // status changes raise the change flags; no qualified osc forces pll select
  task set_st(input int l, input int o);
    if (l != lk) flg |= 8'h10;
    if (o != os) flg |= 8'h02;
    lk = l;
    os = o;
    if (os == 0) sel = 1;
  endtask : set_st

  // request held until the rising edge that sees waitrequest low; data taken
  // and request released at that edge, one idle edge before the next call
  task bus(input logic w, input logic [4:0] a, input logic [7:0] d);
    int n;
    n = 0;
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= {24'h0, d};
    @(posedge mclk_i);
    while (avs_waitrequest !== 1'b0) begin
      if (n == 40) begin
        miscompares++;
        tally_and_finish;
      end
      @(posedge mclk_i);
      n++;
    end
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge mclk_i);
  endtask : bus

  task rd(input logic [4:0] a);
    bus(1'b0, a, 8'h00);
    `CHK(q, exp_rd(a))
    `CHK(can_osc_clk_en_o, os[0])
  endtask : rd

  task wr(input logic [4:0] a, input logic [7:0] d);
    bus(1'b1, a, d);
    case (a)
      5'h00: if (!write_protect && sel) begin synth = d; set_st(0, 0); end
      5'h04: if (!write_protect && sel) begin refd = d & 8'hCF; set_st(0, 0); end
      5'h08: if (sel) post = d & 8'h1F;
      5'h0C: flg &= ~(d & 8'hF6);
      5'h10: begin if (!write_protect) begin sel = d[7]; ext = d[1]; end write_protect = d[0]; if (!os) sel = 1; end
      5'h14: ien = d & 8'h92;
      default: ;
    endcase
    `CHK(irq_o, 1'(|(flg & ien & 8'h92)))
  endtask : wr

  task relock;
    lock_i <= 1'b0;
    repeat (4) @(posedge mclk_i);
    lock_i <= 1'b1;
    repeat (6) @(posedge mclk_i);
    set_st(1, 1);
  endtask : relock

  task tally_and_finish;
    $display("comparisons %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : tally_and_finish

  initial begin
    repeat (5000) @(posedge mclk_i);
    miscompares++;
    tally_and_finish;
  end

  // -----
  // scenarios
  // -----
  initial begin
    {rst_i, ce_i, lvr_i, bad_addr_rst_i, rti_timeout_i, full_stop_i, pseudo_stop_i, lock_i, osc_good_i} <= 9'h180;
    {por_i, avs_read, avs_write, avs_address, avs_writedata, avs_byteenable} <= {3'h4, 37'h0, 4'hF};
    repeat (5) @(posedge mclk_i);
    {rst_i, por_i} <= 2'h0;
    @(posedge mclk_i);
    for (int i = 0; i < 8; i++) rd(5'(i * 4));
    wr(5'h0C, 8'h00);
    wr(5'h0C, 8'h60);
    rd(5'h0C);
    {lvr_i, bad_addr_rst_i, rti_timeout_i} <= 3'h7;
    @(posedge mclk_i);
    {lvr_i, bad_addr_rst_i, rti_timeout_i} <= 3'h0;
    @(posedge mclk_i);
    flg |= 8'hA4;
    rd(5'h0C);
    rst_i <= 1'b1;
    repeat (2) @(posedge mclk_i);
    rst_i <= 1'b0;
    {synth, refd, post, sel, ext, write_protect, ien, flg} = {32'h1, 32'h0, 32'h3, 32'h1, 96'h0, flg & 8'h64};
    @(posedge mclk_i);
    for (int i = 0; i < 8; i++) rd(5'(i * 4));
    wr(5'h14, 8'h80);
    rti_timeout_i <= 1'b1;
    @(posedge mclk_i);
    rti_timeout_i <= 1'b0;
    flg |= 8'h80;
    rd(5'h0C);
    wr(5'h14, 8'h00);
    {lock_i, osc_good_i} <= 2'h3;
    repeat (6) @(posedge mclk_i);
    set_st(1, 1);
    wr(5'h14, 8'h92);
    rd(5'h0C);
    wr(5'h0C, 8'h88);
    rd(5'h0C);
    // the timeout pulse lands on the very edge that takes the clearing write
    fork
      wr(5'h0C, 8'h80);
      begin @(posedge mclk_i); rti_timeout_i <= 1'b1; @(posedge mclk_i); rti_timeout_i <= 1'b0; end
    join
    flg |= 8'h80;
    rd(5'h0C);
    wr(5'h0C, 8'h92);
    wr(5'h10, 8'h81);
    wr(5'h00, 8'h58);
    wr(5'h04, 8'h05);
    rd(5'h00);
    wr(5'h10, 8'h80);
    wr(5'h00, 8'h58);
    rd(5'h0C);
    rd(5'h18);
    relock;
    repeat (6) begin
      seed = lfsr(seed);
      wr(5'h08, seed[7:0]);
      rd(5'h18);
    end
    repeat (4) begin
      seed = lfsr(seed);
      wr(5'h04, seed[7:0]);
      rd(5'h04);
    end
    relock;
    wr(5'h10, 8'h02);
    rd(5'h10);
    `CHK(filter_range_o, 2'(refd >> 6))
    wr(5'h08, 8'h1F);
    wr(5'h00, 8'h11);
    rd(5'h08);
    rd(5'h00);
    rd(5'h18);
    {pseudo_stop_i, lock_i} <= 2'h2;
    repeat (6) @(posedge mclk_i);
    set_st(0, 1);
    rd(5'h0C);
    full_stop_i <= 1'b1;
    repeat (4) @(posedge mclk_i);
    set_st(0, 0);
    rd(5'h0C);
    rd(5'h10);
    // a timeout pulse while the clock enable is low must leave no trace
    ce_i <= 1'b0;
    @(posedge mclk_i);
    rti_timeout_i <= 1'b1;
    @(posedge mclk_i);
    {ce_i, rti_timeout_i} <= 2'h2;
    @(posedge mclk_i);
    rd(5'h0C);
    tally_and_finish;
  end
endmodule : test_pll_clock_config_and_flags
